//--- opad_defines.svh
// Offsets, field positions, windows and reset values of the operand
// address decoder. Assumes inclusion by bare name from design files.
`ifndef OPAD_DEFINES_SVH
`define OPAD_DEFINES_SVH

// ----------
// Register byte offsets on the APB
// ----------
`define OPAD_OFF_OPSEL 12'h000
`define OPAD_OFF_VALUE 12'h004
`define OPAD_OFF_PC 12'h008
`define OPAD_OFF_SEG 12'h00C
`define OPAD_OFF_REGSEL 12'h010
`define OPAD_OFF_FLAGCTL 12'h014
`define OPAD_OFF_PREFIX 12'h018
`define OPAD_OFF_FLAGS 12'h01C
`define OPAD_OFF_ADDR 12'h020
`define OPAD_OFF_IMM 12'h024
`define OPAD_OFF_SPLIT 12'h028
`define OPAD_OFF_REGIDX 12'h02C
`define OPAD_OFF_STATUS 12'h030

// ----------
// Field positions
// ----------
`define OPAD_REGSEL_BREG_LSB 0
`define OPAD_REGSEL_PAIR_LSB 4
`define OPAD_REGSEL_BANK_LSB 8
`define OPAD_FLAG_ZMODE_LSB 0
`define OPAD_FLAG_HMODE_LSB 2
`define OPAD_FLAG_CMODE_LSB 4
`define OPAD_FLAG_ZRES_BIT 6
`define OPAD_FLAG_HRES_BIT 7
`define OPAD_FLAG_CRES_BIT 8
`define OPAD_FLAGS_C_BIT 0
`define OPAD_FLAGS_H_BIT 1
`define OPAD_FLAGS_Z_BIT 2
`define OPAD_FLAGS_BANK_LSB 4
`define OPAD_SPLIT_NIB_LSB 24
`define OPAD_SPLIT_HI_LSB 8
`define OPAD_SPLIT_LO_LSB 0

// ----------
// Address windows and fixed register numbers
// ----------
`define OPAD_SFR_BASE 20'hFFF00
`define OPAD_SADDR_BASE 20'hFFE20
`define OPAD_CALLT_BASE 16'h0080
`define OPAD_NEAR_SEG 4'hF
`define OPAD_ACC_BYTE_REG 3'h1
`define OPAD_ACC_PAIR 2'h0

// ----------
// Reset values
// ----------
`define OPAD_RST_WORD20 20'h00000
`define OPAD_RST_SEG 4'h0
`define OPAD_RST_BANK 2'h0

`endif

//--- opad_pkg.sv
// Types shared by the operand address decoder and its address unit.
// Assumes nothing beyond a SystemVerilog compiler.
package opad_pkg;

    // Operand kinds, selected by a write to the operand select register
    typedef enum logic [3:0] {
        OK_SFR,
        OK_SFRP,
        OK_SADDR,
        OK_SADDRP,
        OK_ABS16,
        OK_ABS16W,
        OK_ABS20,
        OK_CALLT,
        OK_REL8,
        OK_REL16,
        OK_IND,
        OK_IMM16,
        OK_IMM8,
        OK_IMM3
    } opad_kind_type;

    // Four ways an instruction treats one flag
    typedef enum logic [1:0] {
        FM_KEEP,
        FM_CLEAR,
        FM_SET,
        FM_RESULT
    } opad_flag_mode_type;

    // Byte registers in numbering order
    typedef enum logic [2:0] {
        BR_X, BR_A, BR_C, BR_B, BR_E, BR_D, BR_L, BR_H
    } opad_byte_reg_type;

    // Register pairs in numbering order
    typedef enum logic [1:0] {
        PR_ACC, PR_BC, PR_DE, PR_HL
    } opad_pair_type;

endpackage : opad_pkg

//--- opad_addr_if.sv
// Carrier between the decoder top and its address unit.
// Assumes opad_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none

interface opad_addr_if;
    import opad_pkg::*;
    opad_kind_type kind;
    logic [19:0] value;
    logic [19:0] pc;
    logic [3:0] seg;
    logic seg_on;
    logic [19:0] addr;
    logic [15:0] imm;
    logic valid;

    // Top side: supplies the operand, takes the result
    modport user (
        output kind, value, pc, seg, seg_on,
        input addr, imm, valid
    );
    // Address unit side
    modport calc (
        input kind, value, pc, seg, seg_on,
        output addr, imm, valid
    );
endinterface : opad_addr_if

`default_nettype wire

//--- opad_addr_calc.sv
// Combinational address former for one operand.
// Assumes opad_pkg and opad_defines.svh; inputs other than kind are stable registers.
`timescale 1ns/1ps
`default_nettype none
`include "opad_defines.svh"

module opad_addr_calc (
    // Operand in, address and immediate out
    opad_addr_if.calc ops
);
    import opad_pkg::*;

    // Clears bit 0 of an even-only operand address
    function automatic logic [19:0] even_only(input logic [19:0] a);
        even_only = {a[19:1], 1'b0};
    endfunction : even_only

    // Picks the 64 KB segment: near area, or the segment after a prefix
    function automatic logic [19:0] seg_addr(input logic on,
        input logic [3:0] seg, input logic [15:0] off);
        seg_addr = on ? {seg, off} : {`OPAD_NEAR_SEG, off};
    endfunction : seg_addr

    logic [19:0] sext8;
    logic [19:0] sext16;
    logic [19:0] sfr_a;
    logic [19:0] saddr_a;
    logic [15:0] callt_a;

    // Sign extension of branch displacements before the add
    assign sext8 = {{12{ops.value[7]}}, ops.value[7:0]}; // [RULE_10]
    assign sext16 = {{4{ops.value[15]}}, ops.value[15:0]}; // [RULE_10]
    // Fixed windows from an 8-bit offset, call table from a 5-bit one
    assign sfr_a = `OPAD_SFR_BASE | {12'h000, ops.value[7:0]}; // [RULE_03]
    assign saddr_a = `OPAD_SADDR_BASE + {12'h000, ops.value[7:0]}; // [RULE_04]
    assign callt_a = `OPAD_CALLT_BASE | {10'h000, ops.value[4:0], 1'b0}; // [RULE_07]

    // Address and immediate forming per operand kind
    always_comb
    begin
        ops.addr = 20'h00000;
        ops.imm = 16'h0000;
        ops.valid = 1'b1;
        case (ops.kind)
            OK_SFR: ops.addr = sfr_a; // [RULE_03]
            OK_SFRP: ops.addr = even_only(sfr_a); // [RULE_05]
            OK_SADDR: ops.addr = saddr_a; // [RULE_04]
            OK_SADDRP: ops.addr = even_only(saddr_a); // [RULE_05]
            OK_ABS16, OK_IND: ops.addr = seg_addr(ops.seg_on, ops.seg,
                ops.value[15:0]); // [RULE_06] [RULE_09] [RULE_15]
            OK_ABS16W: ops.addr = even_only(seg_addr(ops.seg_on, ops.seg,
                ops.value[15:0])); // [RULE_05] [RULE_15]
            OK_ABS20: ops.addr = ops.value; // [RULE_06]
            OK_CALLT: ops.addr = {4'h0, callt_a}; // [RULE_07] [RULE_05]
            OK_REL8: ops.addr = ops.pc + sext8; // [RULE_10]
            OK_REL16: ops.addr = ops.pc + sext16; // [RULE_10]
            OK_IMM16: ops.imm = ops.value[15:0]; // [RULE_08]
            OK_IMM8: ops.imm = {8'h00, ops.value[7:0]}; // [RULE_08]
            OK_IMM3: ops.imm = {13'h0000, ops.value[2:0]}; // [RULE_08]
            default: ops.valid = 1'b0; // [RULE_17]
        endcase
    end

endmodule : opad_addr_calc

`default_nettype wire

//--- opad_top.sv
// Operand address decoder: APB register front end, register numbering,
// bank selection, flag update and extension-segment prefix tracking.
// Assumes an APB master on pclk and opad_addr_calc for address forming.
//
// Summary of operation
// RULE_01: Byte registers numbered X A C B E D L H
// RULE_02: Pairs numbered accumulator, BC, DE, HL
// RULE_03: Special register operand stays in FFF00H-FFFFFH
// RULE_04: Short direct operand stays in FFE20H-FFF1FH
// RULE_05: Even-only operands force address bit 0 low
// RULE_06: Absolute forms span 20-bit and 16-bit ranges
// RULE_07: Call table entries even within 0080H-00BFH
// RULE_08: Immediates are 16, 8 or 3 bits
// RULE_09: Absolute, immediate, indirect and segment forms supported
// RULE_10: Branch offsets sign-extended, added to PC
// RULE_11: Four banks, chosen by the bank flag
// RULE_12: 20-bit value splits nibble, high, low byte
// RULE_13: A and word pair are the accumulators
// RULE_14: Each flag kept, cleared, set or computed
// RULE_15: Segment prefix covers only the next instruction
// RULE_16: No interrupt or DMA inside a prefix
// RULE_17: Undefined encodings cause no effect
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "opad_defines.svh"

module opad_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoded operand towards the datapath
    output logic [19:0] eff_addr,
    output logic [15:0] operand_imm,
    output logic [4:0] byte_reg_index,
    output logic [4:0] pair_reg_index,
    output logic [2:0] program_state_word,
    // Holds off interrupt and DMA acceptance
    output logic irq_dma_hold
);
    import opad_pkg::*;

    // ----------
    // Functions
    // ----------

    // Applies one of the four flag treatments
    function automatic logic flag_next(input opad_flag_mode_type m,
        input logic old, input logic res);
        case (m)
            FM_KEEP: flag_next = old; // [RULE_14]
            FM_CLEAR: flag_next = 1'b0; // [RULE_14]
            FM_SET: flag_next = 1'b1; // [RULE_14]
            FM_RESULT: flag_next = res; // [RULE_14]
            default: flag_next = old;
        endcase
    endfunction : flag_next

    // Absolute byte register index inside the bank file
    function automatic logic [4:0] breg_index(input logic [1:0] bank,
        input opad_byte_reg_type r);
        breg_index = {bank, r}; // [RULE_01] [RULE_11]
    endfunction : breg_index

    // Index of a pair's low byte register inside the bank file
    function automatic logic [4:0] pair_index(input logic [1:0] bank,
        input opad_pair_type p);
        pair_index = {bank, p, 1'b0}; // [RULE_02] [RULE_11]
    endfunction : pair_index

    // Spreads a 20-bit value into nibble, high and low byte fields
    function automatic logic [31:0] split20(input logic [19:0] v);
        split20 = 32'h00000000;
        split20[`OPAD_SPLIT_NIB_LSB +: 4] = v[19:16]; // [RULE_12]
        split20[`OPAD_SPLIT_HI_LSB +: 8] = v[15:8]; // [RULE_12]
        split20[`OPAD_SPLIT_LO_LSB +: 8] = v[7:0]; // [RULE_12]
    endfunction : split20

    // Says whether an offset holds a register
    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `OPAD_OFF_OPSEL, `OPAD_OFF_VALUE, `OPAD_OFF_PC,
            `OPAD_OFF_SEG, `OPAD_OFF_REGSEL, `OPAD_OFF_FLAGCTL,
            `OPAD_OFF_PREFIX, `OPAD_OFF_FLAGS, `OPAD_OFF_ADDR,
            `OPAD_OFF_IMM, `OPAD_OFF_SPLIT, `OPAD_OFF_REGIDX,
            `OPAD_OFF_STATUS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // ----------
    // State
    // ----------
    opad_kind_type kind_r;
    logic [19:0] value_r;
    logic [19:0] pc_r;
    logic [3:0] seg_r;
    opad_byte_reg_type breg_r;
    opad_pair_type pair_r;
    logic [1:0] bank_r;
    logic [5:0] flagctl_r;
    logic z_r;
    logic h_r;
    logic c_r;
    logic prefix_pend_r;
    logic seg_used_r;
    logic [19:0] addr_r;
    logic [15:0] imm_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic setup;
    logic wr_en;
    opad_kind_type kind_nxt;
    logic issue;

    opad_addr_if ops_if ();

    // ----------
    // APB decode
    // ----------

    // Zero-wait slave: every access phase ends at its first edge
    assign pready = 1'b1;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & is_mapped(paddr);
    assign kind_nxt = opad_kind_type'(pwdata[3:0]);
    // A valid operand select write issues one instruction's operand
    assign issue = wr_en & (paddr == `OPAD_OFF_OPSEL) & ops_if.valid;

    // ----------
    // Address unit
    // ----------

    // Kind comes straight from the bus during the issuing write
    assign ops_if.kind = kind_nxt;
    assign ops_if.value = value_r;
    assign ops_if.pc = pc_r;
    assign ops_if.seg = seg_r;
    assign ops_if.seg_on = prefix_pend_r; // [RULE_15]

    opad_addr_calc u_calc (
        .ops (ops_if.calc)
    );

    // ----------
    // Software written registers
    // ----------

    // Operand value, program counter and segment
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            value_r <= `OPAD_RST_WORD20;
            pc_r <= `OPAD_RST_WORD20;
            seg_r <= `OPAD_RST_SEG;
        end
        else if (wr_en)
        begin
            case (paddr)
                `OPAD_OFF_VALUE: value_r <= pwdata[19:0];
                `OPAD_OFF_PC: pc_r <= pwdata[19:0];
                `OPAD_OFF_SEG: seg_r <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // Register, pair and bank selection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            breg_r <= BR_X;
            pair_r <= PR_ACC;
            bank_r <= `OPAD_RST_BANK;
        end
        else if (wr_en && paddr == `OPAD_OFF_REGSEL)
        begin
            breg_r <= opad_byte_reg_type'(
                pwdata[`OPAD_REGSEL_BREG_LSB +: 3]); // [RULE_01]
            pair_r <= opad_pair_type'(
                pwdata[`OPAD_REGSEL_PAIR_LSB +: 2]); // [RULE_02]
            bank_r <= pwdata[`OPAD_REGSEL_BANK_LSB +: 2]; // [RULE_11]
        end
    end

    // ----------
    // Flag update
    // ----------

    // A flag control write applies its three treatments at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            z_r <= 1'b0;
            h_r <= 1'b0;
            c_r <= 1'b0;
            flagctl_r <= 6'h00;
        end
        else if (wr_en && paddr == `OPAD_OFF_FLAGCTL)
        begin
            flagctl_r <= pwdata[5:0];
            z_r <= flag_next(opad_flag_mode_type'(
                pwdata[`OPAD_FLAG_ZMODE_LSB +: 2]), z_r,
                pwdata[`OPAD_FLAG_ZRES_BIT]); // [RULE_14]
            h_r <= flag_next(opad_flag_mode_type'(
                pwdata[`OPAD_FLAG_HMODE_LSB +: 2]), h_r,
                pwdata[`OPAD_FLAG_HRES_BIT]); // [RULE_14]
            c_r <= flag_next(opad_flag_mode_type'(
                pwdata[`OPAD_FLAG_CMODE_LSB +: 2]), c_r,
                pwdata[`OPAD_FLAG_CRES_BIT]); // [RULE_14]
        end
    end

    // ----------
    // Segment prefix
    // ----------

    // Armed by a prefix write, consumed by the next issued operand
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prefix_pend_r <= 1'b0;
            seg_used_r <= 1'b0;
        end
        else if (wr_en && paddr == `OPAD_OFF_PREFIX && pwdata[0])
        begin
            prefix_pend_r <= 1'b1; // [RULE_16]
        end
        else if (issue)
        begin
            seg_used_r <= prefix_pend_r; // [RULE_15]
            prefix_pend_r <= 1'b0; // [RULE_15]
        end
    end

    // ----------
    // Decoded operand
    // ----------

    // Undefined kinds leave every result untouched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            kind_r <= OK_SFR;
            addr_r <= `OPAD_RST_WORD20;
            imm_r <= 16'h0000;
        end
        else if (issue) // [RULE_17]
        begin
            kind_r <= kind_nxt;
            addr_r <= ops_if.addr; // [RULE_09]
            imm_r <= ops_if.imm; // [RULE_08]
        end
    end

    // ----------
    // Read path
    // ----------

    // Read data selection by offset
    always_comb
    begin
        prdata_nxt = 32'h00000000;
        case (paddr)
            `OPAD_OFF_OPSEL: prdata_nxt[3:0] = kind_r;
            `OPAD_OFF_VALUE: prdata_nxt[19:0] = value_r;
            `OPAD_OFF_PC: prdata_nxt[19:0] = pc_r;
            `OPAD_OFF_SEG: prdata_nxt[3:0] = seg_r;
            `OPAD_OFF_REGSEL:
            begin
                prdata_nxt[`OPAD_REGSEL_BREG_LSB +: 3] = breg_r;
                prdata_nxt[`OPAD_REGSEL_PAIR_LSB +: 2] = pair_r;
                prdata_nxt[`OPAD_REGSEL_BANK_LSB +: 2] = bank_r;
            end
            `OPAD_OFF_FLAGCTL: prdata_nxt[5:0] = flagctl_r;
            `OPAD_OFF_PREFIX: prdata_nxt[0] = prefix_pend_r;
            `OPAD_OFF_FLAGS:
            begin
                prdata_nxt[`OPAD_FLAGS_C_BIT] = c_r;
                prdata_nxt[`OPAD_FLAGS_H_BIT] = h_r;
                prdata_nxt[`OPAD_FLAGS_Z_BIT] = z_r;
                prdata_nxt[`OPAD_FLAGS_BANK_LSB +: 2] = bank_r; // [RULE_11]
            end
            `OPAD_OFF_ADDR: prdata_nxt[19:0] = addr_r;
            `OPAD_OFF_IMM: prdata_nxt[15:0] = imm_r;
            `OPAD_OFF_SPLIT: prdata_nxt = split20(value_r); // [RULE_12]
            `OPAD_OFF_REGIDX:
            begin
                prdata_nxt[4:0] = breg_index(bank_r, breg_r);
                prdata_nxt[12:8] = pair_index(bank_r, pair_r);
                prdata_nxt[20:16] = breg_index(bank_r,
                    opad_byte_reg_type'(`OPAD_ACC_BYTE_REG)); // [RULE_13]
                prdata_nxt[28:24] = pair_index(bank_r,
                    opad_pair_type'(`OPAD_ACC_PAIR)); // [RULE_13]
            end
            `OPAD_OFF_STATUS:
            begin
                prdata_nxt[0] = prefix_pend_r;
                prdata_nxt[1] = seg_used_r;
            end
            default: prdata_nxt = 32'h00000000;
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= pwrite ? 32'h00000000 : prdata_nxt;
            pslverr_r <= ~is_mapped(paddr);
        end
    end

    // ----------
    // Outputs
    // ----------
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign eff_addr = addr_r;
    assign operand_imm = imm_r;
    assign byte_reg_index = breg_index(bank_r, breg_r); // [RULE_01]
    assign pair_reg_index = pair_index(bank_r, pair_r); // [RULE_02]
    assign program_state_word = {z_r, h_r, c_r};
    // Asserted from the prefix until its instruction is issued
    assign irq_dma_hold = prefix_pend_r; // [RULE_16]

endmodule : opad_top

`default_nettype wire

//--- opad_assertions.sv
// Port checks for the operand decoder, bound to opad_top.
// Assumes opad_defines.svh and one pclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "opad_defines.svh"

module opad_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Decoded operand
    input wire logic [19:0] eff_addr,
    input wire logic [15:0] operand_imm,
    input wire logic [4:0] byte_reg_index,
    input wire logic [4:0] pair_reg_index,
    input wire logic irq_dma_hold
);
    logic op_wr;
    logic pf_wr;
    logic [3:0] kind;

    // Accepted writes to the decode and prefix registers
    assign op_wr = psel && penable && pwrite && paddr == `OPAD_OFF_OPSEL;
    assign pf_wr = psel && penable && pwrite && paddr == `OPAD_OFF_PREFIX;
    assign kind = pwdata[3:0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sfr;
        op_wr && kind == 4'h0 |=> eff_addr[19:8] == 12'hFFF;
    endproperty
    a_sfr: assert property (p_sfr)
        else $error("sfr operand left its window");
    property p_saddr;
        op_wr && kind == 4'h2 |=> eff_addr inside {[20'hFFE20:20'hFFF1F]};
    endproperty
    a_saddr: assert property (p_saddr)
        else $error("short address left its window");
    property p_even;
        op_wr && kind inside {4'h1, 4'h3, 4'h5, 4'h7} |=> !eff_addr[0];
    endproperty
    a_even: assert property (p_even)
        else $error("even-only operand gave odd address");
    property p_near;
        op_wr && !irq_dma_hold && kind inside {4'h4, 4'h5, 4'hA}
            |=> eff_addr[19:16] == 4'hF;
    endproperty
    a_near: assert property (p_near)
        else $error("unprefixed operand left top segment");
    property p_imm;
        op_wr && kind == 4'hD |=> operand_imm[15:3] == 13'h0 && !eff_addr;
    endproperty
    a_imm: assert property (p_imm)
        else $error("bit immediate wider than three bits");
    property p_pair;
        !pair_reg_index[0] && pair_reg_index[4:3] == byte_reg_index[4:3];
    endproperty
    a_pair: assert property (p_pair)
        else $error("pair index odd or in another bank");
    property p_arm;
        pf_wr && pwdata[0] |=> irq_dma_hold [*2] or op_wr ##1 1'b1;
    endproperty
    a_arm: assert property (p_arm)
        else $error("prefix did not hold off interrupts");
    property p_release;
        irq_dma_hold && op_wr && kind <= 4'hD |=> !irq_dma_hold;
    endproperty
    a_release: assert property (p_release)
        else $error("prefix outlived its instruction");
    property p_undef;
        op_wr && kind >= 4'hE |=> $stable(eff_addr) && $stable(irq_dma_hold);
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined kind changed state");
endmodule : opad_assertions

bind opad_top opad_assertions u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .eff_addr,
    .operand_imm, .byte_reg_index, .pair_reg_index, .irq_dma_hold
);
`default_nettype wire

//--- opad_apb_master.sv
// APB master model issuing one transfer per call of xfer.
// Assumes a slave sampling on the rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none

module opad_apb_master (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // Setup, access held until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer
endmodule : opad_apb_master
`default_nettype wire

//--- operand_address_decode_tb.sv
// Self-checking bench for the operand address decoder.
// Assumes opad_top, the APB master model and the checker.
`timescale 1ns/1ps
`default_nettype none
`include "opad_defines.svh"

module operand_address_decode_tb;
    import opad_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic irq_dma_hold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [19:0] eff_addr;
    logic [15:0] operand_imm;
    logic [4:0] byte_reg_index, pair_reg_index;
    logic [2:0] program_state_word;
    int fail_count, compares;
    // Kind, value, pc, address, immediate
    localparam logic [79:0] TA [18] = '{
        80'h0_12345_00000_FFF45_0000, 80'h1_000FF_00000_FFFFE_0000,
        80'h2_00000_00000_FFE20_0000, 80'h2_000FF_00000_FFF1F_0000,
        80'h3_00001_00000_FFE20_0000, 80'h4_1ABCD_00000_FABCD_0000,
        80'h5_0FFFF_00000_FFFFE_0000, 80'h6_FFFFF_00000_FFFFF_0000,
        80'h6_00000_00000_00000_0000, 80'h7_0001F_00000_000BE_0000,
        80'h7_00000_00000_00080_0000, 80'h8_00080_00100_00080_0000,
        80'h8_0007F_FFFF0_0006F_0000, 80'h9_08000_00010_F8010_0000,
        80'hA_00123_00000_F0123_0000, 80'hB_1ABCD_00000_00000_ABCD,
        80'hC_1ABCD_00000_00000_00CD, 80'hD_1ABCD_00000_00000_0005};
    // Flag control word and resulting zero, half-carry, carry
    localparam logic [11:0] FT [5] = '{12'h02A, 12'h015, 12'h17F,
        12'h1C0, 12'h039};
    localparam logic [2:0] FE [5] = '{3'h7, 3'h0, 3'h5, 3'h5, 3'h2};

    opad_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eff_addr(eff_addr), .operand_imm(operand_imm),
        .byte_reg_index(byte_reg_index), .pair_reg_index(pair_reg_index),
        .program_state_word(program_state_word),
        .irq_dma_hold(irq_dma_hold));
    opad_apb_master bus (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Clock of 40 ns
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Write, then let the causing edge's updates land
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        bus.xfer(1'b1, a, d, q, e);
        @(negedge pclk);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        bus.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd

    task automatic t_regs();
        logic [31:0] q;
        logic [1:0] b;
        for (int r = 0; r < 8; r++)
        begin
            b = r[1:0];
            wr(`OPAD_OFF_REGSEL, 32'(r) | 32'(r[2:1]) << 4 | 32'(b) << 8);
            chk({27'h0, byte_reg_index}, {27'h0, b, r[2:0]});
            chk({27'h0, pair_reg_index}, {27'h0, b, r[2:1], 1'b0});
            rd(`OPAD_OFF_REGIDX, q);
            chk(q & 32'h1F1F0000, {3'h0, b, 6'h0, b, BR_A, 16'h0});
            rd(`OPAD_OFF_FLAGS, q);
            chk(q & 32'h30, {26'h0, b, 4'h0});
        end
        $display("t_regs done");
    endtask : t_regs

    task automatic t_addr();
        for (int i = 0; i < 18; i++)
        begin
            wr(`OPAD_OFF_VALUE, {12'h0, TA[i][75:56]});
            wr(`OPAD_OFF_PC, {12'h0, TA[i][55:36]});
            wr(`OPAD_OFF_OPSEL, {28'h0, TA[i][79:76]});
            chk({12'h0, eff_addr}, {12'h0, TA[i][35:16]});
            chk({16'h0, operand_imm}, {16'h0, TA[i][15:0]});
        end
        $display("t_addr done");
    endtask : t_addr

    task automatic t_prefix();
        logic [31:0] q;
        wr(`OPAD_OFF_SEG, 32'h3);
        wr(`OPAD_OFF_VALUE, 32'h01234);
        wr(`OPAD_OFF_PREFIX, 32'h1);
        chk({31'h0, irq_dma_hold}, 32'h1);
        wr(`OPAD_OFF_OPSEL, 32'hE);
        wr(`OPAD_OFF_OPSEL, 32'hF);
        chk({11'h0, eff_addr, irq_dma_hold}, 32'h1);
        wr(`OPAD_OFF_OPSEL, {28'h0, OK_ABS16});
        chk({11'h0, eff_addr, irq_dma_hold}, 32'h62468);
        rd(`OPAD_OFF_STATUS, q);
        chk(q, 32'h2);
        wr(`OPAD_OFF_OPSEL, {28'h0, OK_ABS16});
        chk({12'h0, eff_addr}, 32'hF1234);
        $display("t_prefix done");
    endtask : t_prefix

    task automatic t_flags();
        logic [31:0] q;
        for (int i = 0; i < 5; i++)
        begin
            wr(`OPAD_OFF_FLAGCTL, {20'h0, FT[i]});
            chk({29'h0, program_state_word}, {29'h0, FE[i]});
            rd(`OPAD_OFF_FLAGS, q);
            chk(q & 32'h7, {29'h0, FE[i]});
        end
        $display("t_flags done");
    endtask : t_flags

    // Split fields, refused and read-only accesses
    task automatic t_bus();
        logic [31:0] q;
        logic e;
        wr(`OPAD_OFF_VALUE, 32'hFFFA5C3E);
        rd(`OPAD_OFF_SPLIT, q);
        chk(q, 32'h0A005C3E);
        bus.xfer(1'b1, 12'h006, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        bus.xfer(1'b0, 12'h034, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        wr(`OPAD_OFF_FLAGS, 32'hFF);
        rd(`OPAD_OFF_VALUE, q);
        chk(q, 32'h000A5C3E);
        rd(`OPAD_OFF_FLAGS, q);
        chk(q, 32'h32);
        $display("t_bus done");
    endtask : t_bus

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // Reset for four cycles, then the scenarios
    initial
    begin
        presetn = 1'b0;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk({eff_addr, operand_imm[11:0]}, 32'h0);
        chk({22'h0, byte_reg_index, program_state_word, 2'h0}, 32'h0);
        t_regs();
        t_addr();
        t_prefix();
        t_flags();
        t_bus();
        close_out();
    end

    // Watchdog well past the 103 transfers above
    initial
    begin
        #2000000;
        fail_count++;
        close_out();
    end
endmodule : operand_address_decode_tb
`default_nettype wire
